// ===== rtl/flash_program_erase_control.sv
// flash program/erase control register, sequence interlock and high-voltage gating
//
// Operation
// (R01) high-voltage enable bit one drives pump and array high voltage; zero turns both off.
// (R02) high-voltage enable is accepted only with program or erase set and sequence followed.
// (R03) whole-array select picks mass erase when one, page erase when zero; readable.
// (R04) program and erase select are never both one nor set together.
// (R05) page erase clears one 512-byte page aligned on 0x200.
// (R06) page erase never clears the vector page; only mass erase does.
// (R07) software sets erase, clears whole-array, then writes anywhere inside the page.
// (R08) software waits 5 us after the page write before setting high voltage.
// (R09) software waits 20 ms with high voltage before clearing erase select.
// (R10) software waits 5 us hold time after clearing erase select.
// (R11) software then clears high-voltage enable to stop the pump.
// (R12) reset clears all four control bits.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_consts.svh"
module flash_program_erase_control
    import fpe_pkg::*;
#(
    parameter int unsigned TNVS_CYC = `FPE_TNVS_CYC,
    parameter int unsigned TERASE_CYC = `FPE_TERASE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [`FPE_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // cpu writes into the flash array
    input wire logic flash_wr,
    input wire logic [15:0] flash_wr_addr,
    // flash array and charge pump
    output logic charge_pump_en,
    output logic array_hv_en,
    output logic program_mode,
    output logic erase_mode,
    output logic mass_erase,
    output logic page_erase_en,
    output logic [`FPE_PAGE_W-1:0] erase_page
);
    logic [3:0] ctrl_reg;
    logic [3:0] ctrl_next;
    seq_state_e seq_state_reg;
    seq_state_e seq_state_next;
    logic [`FPE_PAGE_W-1:0] page_reg;
    logic page_prot;
    logic nvs_done;
    logic erase_done;
    logic req;
    logic take;
    logic ctrl_wr;
    logic sel_any;
    logic hv_allowed;

    function automatic logic [15:0] reg_index(input logic [`FPE_ADDR_W-1:0] addr);
        reg_index = addr[`FPE_ADDR_W-1:2];
    endfunction

    function automatic logic hits(input logic [`FPE_ADDR_W-1:0] addr, input logic [15:0] idx);
        hits = (reg_index(addr) == idx) && (addr[1:0] == 2'b00);
    endfunction

    // bus handshake: one wait state, request taken while waitrequest is low
    assign req = avs_read || avs_write;
    assign take = req && !avs_waitrequest;
    assign ctrl_wr = take && avs_write && avs_byteenable[0] && hits(avs_address, `FPE_CTRL_IDX);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= !(req && avs_waitrequest);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && avs_waitrequest)
        begin
            if (hits(avs_address, `FPE_CTRL_IDX))
            begin
                avs_readdata <= {28'h000_0000, ctrl_reg};
            end
            else if (hits(avs_address, `FPE_STAT_IDX))
            begin
                avs_readdata <= {16'h0000, 1'b0, page_reg, 3'h0, page_prot, erase_done,
                    nvs_done, seq_state_reg};
            end
            else
            begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // control register write with interlocks
    assign sel_any = ctrl_reg[`FPE_BIT_PROG] || ctrl_reg[`FPE_BIT_ERASE];
    assign hv_allowed = sel_any && (seq_state_reg == SEQ_LATCHED) && nvs_done; // [R02]

    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr)
        begin
            ctrl_next[`FPE_BIT_MASS] = avs_writedata[`FPE_BIT_MASS]; // [R03]
            if (!(avs_writedata[`FPE_BIT_PROG] && avs_writedata[`FPE_BIT_ERASE])) // [R04]
            begin
                ctrl_next[`FPE_BIT_PROG] = avs_writedata[`FPE_BIT_PROG];
                ctrl_next[`FPE_BIT_ERASE] = avs_writedata[`FPE_BIT_ERASE];
            end
            if (!avs_writedata[`FPE_BIT_HV])
            begin
                ctrl_next[`FPE_BIT_HV] = 1'b0;
            end
            else if (hv_allowed || ctrl_reg[`FPE_BIT_HV]) // [R02]
            begin
                ctrl_next[`FPE_BIT_HV] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_reg <= `FPE_CTRL_RESET; // [R12]
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // sequence tracker
    always_comb
    begin
        seq_state_next = seq_state_reg;
        case (seq_state_reg)
            SEQ_IDLE:
            begin
                if (sel_any)
                begin
                    seq_state_next = SEQ_SELECTED;
                end
            end
            SEQ_SELECTED:
            begin
                if (!sel_any)
                begin
                    seq_state_next = SEQ_IDLE;
                end
                else if (flash_wr)
                begin
                    seq_state_next = SEQ_LATCHED;
                end
            end
            SEQ_LATCHED:
            begin
                if (ctrl_reg[`FPE_BIT_HV])
                begin
                    seq_state_next = SEQ_HV;
                end
                else if (!sel_any)
                begin
                    seq_state_next = SEQ_IDLE;
                end
            end
            SEQ_HV:
            begin
                if (!ctrl_reg[`FPE_BIT_HV])
                begin
                    seq_state_next = sel_any ? SEQ_SELECTED : SEQ_IDLE;
                end
            end
            default:
            begin
                seq_state_next = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seq_state_reg <= SEQ_IDLE;
        end
        else
        begin
            seq_state_reg <= seq_state_next;
        end
    end

    // page latch from the page-selecting array write
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            page_reg <= '0;
        end
        else if (flash_wr && seq_state_reg == SEQ_SELECTED && sel_any)
        begin
            page_reg <= flash_wr_addr[15:`FPE_PAGE_SHIFT]; // [R05]
        end
    end

    assign page_prot = (page_reg == `FPE_VECTOR_PAGE); // [R06]

    fpe_delay_timer #(
        .CYCLES(TNVS_CYC)
    ) u_nvs_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(seq_state_reg == SEQ_SELECTED && flash_wr && sel_any),
        .clear(seq_state_reg == SEQ_IDLE),
        .done_reg(nvs_done)
    );

    fpe_delay_timer #(
        .CYCLES(TERASE_CYC)
    ) u_erase_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(seq_state_reg == SEQ_LATCHED && ctrl_reg[`FPE_BIT_HV]),
        .clear(!ctrl_reg[`FPE_BIT_HV]),
        .done_reg(erase_done)
    );

    // array controls
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            page_erase_en <= 1'b0;
        end
        else
        begin
            page_erase_en <= ctrl_reg[`FPE_BIT_HV] && ctrl_reg[`FPE_BIT_ERASE]
                && !ctrl_reg[`FPE_BIT_MASS] && !page_prot; // [R03] [R06]
        end
    end

    assign charge_pump_en = ctrl_reg[`FPE_BIT_HV]; // [R01]
    assign array_hv_en = ctrl_reg[`FPE_BIT_HV]; // [R01]
    assign program_mode = ctrl_reg[`FPE_BIT_PROG];
    assign erase_mode = ctrl_reg[`FPE_BIT_ERASE];
    assign mass_erase = ctrl_reg[`FPE_BIT_MASS];
    assign erase_page = page_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_pump_on;
        charge_pump_en && array_hv_en;
    endsequence

    sequence s_page_write;
        flash_wr && seq_state_reg == SEQ_SELECTED && sel_any;
    endsequence

    a_pump_tracks_high_voltage_enable: assert property (@(posedge sys_clk) disable iff (!nrst) // [R01]
        $rose(charge_pump_en) |-> s_pump_on ##0 $past(ctrl_wr))
        else $error("pump on without high-voltage write");
    a_hv_needs_seq: assert property ($rose(charge_pump_en) |-> // [R02]
        $past(seq_state_reg) == SEQ_LATCHED && $past(nvs_done) && $past(sel_any))
        else $error("high voltage set out of sequence");
    a_mass_blocks_page: assert property ((s_pump_on ##0 mass_erase) |=> !page_erase_en) // [R03]
        else $error("page erase active during mass erase");
    a_interlock_sel: assert property (!(program_mode && erase_mode)) // [R04]
        else $error("program and erase both selected");
    a_page_latch: assert property (s_page_write |=> // [R05]
        erase_page == $past(flash_wr_addr[15:`FPE_PAGE_SHIFT]))
        else $error("erase page not latched from write address");
    a_vector_guard: assert property (page_erase_en |-> erase_page != `FPE_VECTOR_PAGE) // [R06]
        else $error("page erase on vector page");
    a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0) // [R12]
        !nrst |-> ctrl_reg == 4'h0)
        else $error("control bits not cleared in reset");
    a_bus_one_wait: assert property ((req && avs_waitrequest) |=> !avs_waitrequest ##1
        avs_waitrequest)
        else $error("bus wait state not exactly one cycle");
endmodule
`default_nettype wire

// ===== rtl/fpe_consts.svh
// offsets, field positions, reset values and timing counts of the flash control block
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH

// register indices; byte address is four times the index
`define FPE_CTRL_IDX 16'hFE08
`define FPE_STAT_IDX 16'hFE0A
`define FPE_ADDR_W 18

// control register field positions
`define FPE_BIT_PROG 0
`define FPE_BIT_ERASE 1
`define FPE_BIT_MASS 2
`define FPE_BIT_HV 3
`define FPE_CTRL_RESET 4'h0

// page geometry
`define FPE_PAGE_SHIFT 9
`define FPE_PAGE_W 7
`define FPE_VECTOR_PAGE 7'h7F

// timing
`define FPE_CLK_NS 10
`define FPE_TNVS_NS 5000
`define FPE_TERASE_MS 20
`define FPE_TNVS_CYC ((`FPE_TNVS_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`define FPE_TERASE_CYC ((`FPE_TERASE_MS * 1000000) / `FPE_CLK_NS)

`endif

// ===== rtl/fpe_pkg.sv
// types shared by the flash control block
`default_nettype none
package fpe_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SELECTED = 2'b01,
        SEQ_LATCHED = 2'b11,
        SEQ_HV = 2'b10
    } seq_state_e;
endpackage
`default_nettype wire

// ===== rtl/fpe_delay_timer.sv
// one-shot delay timer: done rises a fixed number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module fpe_delay_timer #(
    parameter int unsigned CYCLES = 500,
    parameter int unsigned W = $clog2(CYCLES + 1)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic clear,
    // status
    output logic done_reg
);
    logic [W-1:0] cnt_reg;
    logic running_reg;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_reg <= '0;
            running_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (clear)
        begin
            running_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= W'(CYCLES - 1);
            running_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (running_reg)
        begin
            if (cnt_reg == '0)
            begin
                running_reg <= 1'b0;
                done_reg <= 1'b1;
            end
            else
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/flash_array_model.sv
// flash array and charge pump model: logs page and mass erases
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // controls from the block
    input wire logic charge_pump_en,
    input wire logic array_hv_en,
    input wire logic page_erase_en,
    input wire logic mass_erase,
    input wire logic erase_mode,
    input wire logic [6:0] erase_page,
    // observation
    output logic [7:0] page_cnt,
    output logic [7:0] mass_cnt,
    output logic [15:0] erased_base
);
    logic pe_reg;
    logic me_reg;
    wire logic hv_on = charge_pump_en & array_hv_en;
    wire logic me_now = hv_on & erase_mode & mass_erase;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pe_reg <= 1'b0;
            me_reg <= 1'b0;
            page_cnt <= 8'h00;
            mass_cnt <= 8'h00;
            erased_base <= 16'h0000;
        end
        else
        begin
            pe_reg <= page_erase_en;
            me_reg <= me_now;
            if (page_erase_en && !pe_reg)
            begin
                page_cnt <= page_cnt + 8'h01;
                erased_base <= {erase_page, 9'h000};
            end
            if (me_now && !me_reg)
                mass_cnt <= mass_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== tb/flash_program_erase_control_bench.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`default_nettype none
`include "fpe_consts.svh"
module flash_program_erase_control_bench
    import fpe_pkg::*;
;
    localparam logic [17:0] CTRL = {`FPE_CTRL_IDX, 2'b00};
    localparam logic [17:0] HOLE = 18'h00100;
    localparam logic [17:0] STAT = {`FPE_STAT_IDX, 2'b00};
    localparam logic [7:0] ROWS [9] = '{8'h11, 8'h31, 8'h00, 8'h22, 8'h66, 8'hE6, 8'h44, 8'h91,
        8'h00};
    logic sys_clk = 1'b0;
    logic nrst = 1'b1;
    logic [17:0] avs_address = 18'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic flash_wr = 1'b0;
    logic [15:0] flash_wr_addr = 16'h0;
    logic charge_pump_en, array_hv_en, program_mode, erase_mode, mass_erase, page_erase_en;
    logic [6:0] erase_page;
    logic [7:0] page_cnt, mass_cnt;
    logic [15:0] erased_base;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] q;

    always #5 sys_clk = ~sys_clk;

    flash_program_erase_control #(.TNVS_CYC(8), .TERASE_CYC(50)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flash_wr(flash_wr),
        .flash_wr_addr(flash_wr_addr), .charge_pump_en(charge_pump_en),
        .array_hv_en(array_hv_en), .program_mode(program_mode), .erase_mode(erase_mode),
        .mass_erase(mass_erase), .page_erase_en(page_erase_en), .erase_page(erase_page));

    flash_array_model model_u (
        .sys_clk(sys_clk), .nrst(nrst), .charge_pump_en(charge_pump_en),
        .array_hv_en(array_hv_en), .page_erase_en(page_erase_en), .mass_erase(mass_erase),
        .erase_mode(erase_mode), .erase_page(erase_page), .page_cnt(page_cnt),
        .mass_cnt(mass_cnt), .erased_base(erased_base));

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic [17:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] be);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
        begin
            @(posedge sys_clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] v);
        bus(CTRL, 1'b1, {28'h0, v}, 4'hF);
    endtask

    task automatic rd(input logic [17:0] a, input logic [3:0] exp);
        bus(a, 1'b0, 32'h0, 4'hF);
        chk(q, {28'h0, exp});
    endtask

    task automatic pins(input logic [3:0] exp);
        chk({28'h0, charge_pump_en, mass_erase, erase_mode, program_mode}, {28'h0, exp});
    endtask

    task automatic latch_page(input logic [3:0] v, input logic [15:0] a);
        wr(v);
        flash_wr <= 1'b1;
        flash_wr_addr <= a;
        @(posedge sys_clk);
        flash_wr <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask

    initial
    begin
        #200000;
        err_total++;
        test_done();
    end

    initial
    begin
        nrst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(CTRL, 4'h0);
        pins(4'h0);
        for (int i = 0; i < 9; i++)
        begin
            wr(ROWS[i][7:4]);
            rd(CTRL, ROWS[i][3:0]);
            pins(ROWS[i][3:0]);
        end
        bus(HOLE, 1'b1, 32'h2, 4'hF);
        rd(HOLE, 4'h0);
        bus(CTRL, 1'b1, 32'h2, 4'hE);
        rd(CTRL, 4'h0);
        // page erase, first high-voltage attempt before the latch
        wr(4'h2);
        wr(4'hA);
        rd(CTRL, 4'h2);
        latch_page(4'h2, 16'h1234);
        bus(STAT, 1'b0, 32'h0, 4'hF);
        chk(q, 32'h0000_0907);
        wr(4'hA);
        rd(CTRL, 4'hA);
        chk({30'h0, charge_pump_en, array_hv_en}, 32'h3);
        chk({16'h0, page_cnt, 1'b0, erase_page}, {24'h1, 8'h09});
        chk({16'h0, erased_base}, 32'h1200);
        repeat (50) @(posedge sys_clk);
        bus(STAT, 1'b0, 32'h0, 4'hF);
        chk(q, 32'h0000_090E);
        wr(4'h8);
        rd(CTRL, 4'h8);
        repeat (8) @(posedge sys_clk);
        wr(4'h0);
        pins(4'h0);
        // vector page refuses a page erase
        latch_page(4'h2, 16'hFE10);
        wr(4'hA);
        chk({23'h0, page_erase_en, page_cnt}, 32'h1);
        wr(4'h0);
        latch_page(4'h6, 16'h0800);
        wr(4'hE);
        rd(CTRL, 4'hE);
        chk({23'h0, page_erase_en, mass_cnt}, 32'h1);
        // reset in mid erase
        nrst <= 1'b0;
        @(posedge sys_clk);
        chk({25'h0, charge_pump_en, array_hv_en, program_mode, erase_mode, mass_erase,
            page_erase_en, avs_waitrequest}, 32'h1);
        chk({25'h0, erase_page}, 32'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(CTRL, 4'h0);
        test_done();
    end
endmodule
`default_nettype wire
